// ==== ldpr_core.sv ====
// Large dual-port RAM block: storage array, port input registers and read paths
`timescale 1ns/1ps
// How it works
// - 4K words of 144 bits, parity included
// - True dual, simple dual, single port, FIFO
// - Storage array has no reset or preload
// - All port inputs but the clears pass an input register
// - Output register per port, bypass selectable
// - Five depth/width shapes, 8- or 9-bit lanes
// - 144-bit shape refused in true dual mode
// - Mixed widths allowed; 144 pairs only itself
// - One write select decides read or write
// - Lane written when select and mask high
// - Masks for 18, 36, 72-bit widths
// - Port masks joined for 144-bit writes
// - Mask bit i covers bits 9i..9i+8
// - Any mask pattern stores selected lanes
// - 8-bit shapes use same lane order
// - Each port's input registers use that port's own clock enable
// - Per-port enable, select, clear honoured separately
// - 72-bit write and read buses per port
// - 16-bit address and 8-bit mask per port
// - Masked lanes keep their stored contents
// - Port A regs on A side, B on B
// - Per-port clock enable and clear
module ldpr_core (
    input  wire  logic                           mclk,
    input  wire  logic                           rst_n,
    input  wire  ldpr_pkg::ldpr_cfg_s            cfg,
    input  wire  logic                           ce_a,
    input  wire  logic                           clr_a,
    input  wire  ldpr_pkg::ldpr_port_s           port_a,
    input  wire  logic                           ce_b,
    input  wire  logic                           clr_b,
    input  wire  ldpr_pkg::ldpr_port_s           port_b,
    output logic [ldpr_pkg::PORT_DATA-1:0]       dout_a,
    output logic [ldpr_pkg::PORT_DATA-1:0]       dout_b,
    output logic                                 cfg_error
);

    // Base-two log of the lanes per port word
    function automatic logic [ldpr_pkg::LG_W-1:0] width_lg(input ldpr_pkg::ldpr_width_e w);
        unique case (w)
            ldpr_pkg::WIDTH_9:   width_lg = 3'h0;
            ldpr_pkg::WIDTH_18:  width_lg = 3'h1;
            ldpr_pkg::WIDTH_36:  width_lg = 3'h2;
            ldpr_pkg::WIDTH_72:  width_lg = 3'h3;
            ldpr_pkg::WIDTH_144: width_lg = 3'h4;
            default:             width_lg = 3'h0;
        endcase
    endfunction : width_lg

    function automatic logic legal_cfg(input ldpr_pkg::ldpr_cfg_s c);
        logic wide_a;
        logic wide_b;
        wide_a = (c.width_a == ldpr_pkg::WIDTH_144);
        wide_b = (c.width_b == ldpr_pkg::WIDTH_144);
        legal_cfg = 1'b1;
        if (c.width_a > ldpr_pkg::WIDTH_144 || c.width_b > ldpr_pkg::WIDTH_144) begin
            legal_cfg = 1'b0;
        end
        unique case (c.mode)
            ldpr_pkg::MODE_TRUE_DUAL: begin
                if (wide_a || wide_b) legal_cfg = 1'b0;
            end
            ldpr_pkg::MODE_SINGLE: begin
                // B is unused here, yet a 144 shape on either port still makes the shape illegal
                if (wide_a || wide_b) legal_cfg = 1'b0;
            end
            default: begin
                if (wide_a != wide_b) legal_cfg = 1'b0;
            end
        endcase
    endfunction : legal_cfg

    function automatic logic [ldpr_pkg::WIDX_W-1:0] word_idx(
        input logic [ldpr_pkg::ADDR_W-1:0] addr,
        input logic [ldpr_pkg::LG_W-1:0]   lg
    );
        logic [ldpr_pkg::ADDR_W-1:0] t;
        t = addr >> (ldpr_pkg::LG_MAX - int'(lg));
        word_idx = t[ldpr_pkg::WIDX_W-1:0];
    endfunction : word_idx

    function automatic logic [ldpr_pkg::SLOT_W-1:0] slot_idx(
        input logic [ldpr_pkg::ADDR_W-1:0] addr,
        input logic [ldpr_pkg::LG_W-1:0]   lg
    );
        logic [ldpr_pkg::SLOT_W-1:0] m;
        m = ldpr_pkg::SLOT_W'((ldpr_pkg::NUM_LANES >> int'(lg)) - 1);
        slot_idx = addr[ldpr_pkg::SLOT_W-1:0] & m;
    endfunction : slot_idx

    // Lane j of the word takes mask bit (j mod lanes) in slot (j / lanes)
    function automatic logic [ldpr_pkg::NUM_LANES-1:0] lane_en(
        input logic [ldpr_pkg::LG_W-1:0]      lg,
        input logic [ldpr_pkg::SLOT_W-1:0]    slot,
        input logic [ldpr_pkg::NUM_LANES-1:0] mask
    );
        int k;
        int g;
        lane_en = '0;
        for (int j = 0; j < ldpr_pkg::NUM_LANES; j++) begin
            k = j & ((1 << int'(lg)) - 1);
            g = j >> int'(lg);
            lane_en[j] = (g == int'(slot)) && ((lg == '0) || mask[k]);
        end
    endfunction : lane_en

    // Spread port write data over all lanes; 8-bit lanes leave parity bit aside
    function automatic logic [ldpr_pkg::WORD_BITS-1:0] place(
        input logic [ldpr_pkg::WORD_BITS-1:0] wd,
        input logic [ldpr_pkg::LG_W-1:0]      lg,
        input logic                           byte8
    );
        int k;
        place = '0;
        for (int j = 0; j < ldpr_pkg::NUM_LANES; j++) begin
            k = j & ((1 << int'(lg)) - 1);
            if (byte8) begin
                place[j*ldpr_pkg::LANE_BITS +: ldpr_pkg::BYTE_BITS] =
                    wd[k*ldpr_pkg::BYTE_BITS +: ldpr_pkg::BYTE_BITS];
            end else begin
                place[j*ldpr_pkg::LANE_BITS +: ldpr_pkg::LANE_BITS] =
                    wd[k*ldpr_pkg::LANE_BITS +: ldpr_pkg::LANE_BITS];
            end
        end
    endfunction : place

    // Gather the addressed slot of a stored word into port-order read data
    function automatic logic [ldpr_pkg::WORD_BITS-1:0] gather(
        input logic [ldpr_pkg::WORD_BITS-1:0] word,
        input logic [ldpr_pkg::LG_W-1:0]      lg,
        input logic [ldpr_pkg::SLOT_W-1:0]    slot,
        input logic                           byte8
    );
        int src;
        gather = '0;
        for (int k = 0; k < ldpr_pkg::NUM_LANES; k++) begin
            src = (int'(slot) << int'(lg)) + k;
            if (k < (1 << int'(lg))) begin
                if (byte8) begin
                    gather[k*ldpr_pkg::BYTE_BITS +: ldpr_pkg::BYTE_BITS] =
                        word[src*ldpr_pkg::LANE_BITS +: ldpr_pkg::BYTE_BITS];
                end else begin
                    gather[k*ldpr_pkg::LANE_BITS +: ldpr_pkg::LANE_BITS] =
                        word[src*ldpr_pkg::LANE_BITS +: ldpr_pkg::LANE_BITS];
                end
            end
        end
    endfunction : gather

    // Captured request acts only under a legal shape, with select and mode agreeing
    function automatic logic port_op(
        input logic ok_shape,
        input logic vld,
        input logic we,
        input logic want_we,
        input logic allowed
    );
        port_op = ok_shape && vld && (we == want_we) && allowed;
    endfunction : port_op

    logic [ldpr_pkg::WORD_BITS-1:0] mem [ldpr_pkg::NUM_WORDS];

    ldpr_pkg::ldpr_port_s           in_a_q;
    ldpr_pkg::ldpr_port_s           in_b_q;
    logic                           vld_a_q;
    logic                           vld_b_q;
    logic [ldpr_pkg::WORD_BITS-1:0] raw_a_q;
    logic [ldpr_pkg::WORD_BITS-1:0] raw_b_q;
    logic [ldpr_pkg::WORD_BITS-1:0] out_a_q;
    logic [ldpr_pkg::WORD_BITS-1:0] out_b_q;

    logic                           legal;
    logic                           wide;
    logic                           a_wr_ok;
    logic                           a_rd_ok;
    logic                           b_wr_ok;
    logic                           b_rd_ok;
    logic                           wr_a;
    logic                           wr_b;
    logic                           rd_a;
    logic                           rd_b;
    logic [ldpr_pkg::LG_W-1:0]      lg_a;
    logic [ldpr_pkg::LG_W-1:0]      lg_b;
    logic [ldpr_pkg::WIDX_W-1:0]    widx_a;
    logic [ldpr_pkg::WIDX_W-1:0]    widx_b;
    logic [ldpr_pkg::SLOT_W-1:0]    slot_a;
    logic [ldpr_pkg::SLOT_W-1:0]    slot_b;
    logic [ldpr_pkg::NUM_LANES-1:0] mask_a;
    logic [ldpr_pkg::NUM_LANES-1:0] mask_b;
    logic [ldpr_pkg::NUM_LANES-1:0] en_a;
    logic [ldpr_pkg::NUM_LANES-1:0] en_b;
    logic [ldpr_pkg::WORD_BITS-1:0] wd_a;
    logic [ldpr_pkg::WORD_BITS-1:0] wd_b;
    logic [ldpr_pkg::WORD_BITS-1:0] pd_a;
    logic [ldpr_pkg::WORD_BITS-1:0] pd_b;
    logic [ldpr_pkg::WORD_BITS-1:0] sel_a;
    logic [ldpr_pkg::WORD_BITS-1:0] sel_b;

    // Mode decides which port may read and which may write
    always_comb begin
        legal   = legal_cfg(cfg);
        wide    = (cfg.width_a == ldpr_pkg::WIDTH_144);
        a_wr_ok = 1'b1;
        a_rd_ok = 1'b1;
        b_wr_ok = 1'b1;
        b_rd_ok = 1'b1;
        unique case (cfg.mode)
            ldpr_pkg::MODE_TRUE_DUAL: begin
            end
            ldpr_pkg::MODE_SINGLE: begin
                b_wr_ok = 1'b0;
                b_rd_ok = 1'b0;
            end
            default: begin
                a_rd_ok = 1'b0;
                b_wr_ok = 1'b0;
            end
        endcase
    end

    assign cfg_error = ~legal;

    // Input registers of each port load on that port's enable; the valid flag takes the enable every edge
    always_ff @(posedge mclk) begin
        if (!rst_n || clr_a) begin
            in_a_q  <= '0;
            vld_a_q <= 1'b0;
        end else begin
            vld_a_q <= ce_a;
            if (ce_a) begin
                in_a_q <= port_a;
            end
        end
    end

    // Port B input registers; in a 144 write they carry the upper half
    always_ff @(posedge mclk) begin
        if (!rst_n || clr_b) begin
            in_b_q  <= '0;
            vld_b_q <= 1'b0;
        end else begin
            vld_b_q <= ce_b;
            if (ce_b) begin
                in_b_q <= port_b;
            end
        end
    end

    // Address split and lane steering per port shape
    always_comb begin
        lg_a   = width_lg(cfg.width_a);
        lg_b   = width_lg(cfg.width_b);
        widx_a = word_idx(in_a_q.addr, lg_a);
        widx_b = word_idx(in_b_q.addr, lg_b);
        slot_a = slot_idx(in_a_q.addr, lg_a);
        slot_b = slot_idx(in_b_q.addr, lg_b);
        mask_a = wide ? {in_b_q.mask, in_a_q.mask}
                      : {{ldpr_pkg::MASK_W{1'b1}}, in_a_q.mask};
        mask_b = {{ldpr_pkg::MASK_W{1'b1}}, in_b_q.mask};
        wd_a   = {in_b_q.wdata, in_a_q.wdata};
        wd_b   = {{ldpr_pkg::PORT_DATA{1'b0}}, in_b_q.wdata};
        en_a   = lane_en(lg_a, slot_a, mask_a);
        en_b   = lane_en(lg_b, slot_b, mask_b);
        pd_a   = place(wd_a, lg_a, cfg.byte8_a);
        pd_b   = place(wd_b, lg_b, cfg.byte8_b);
        wr_a   = port_op(legal, vld_a_q, in_a_q.we, 1'b1, a_wr_ok);
        wr_b   = port_op(legal, vld_b_q, in_b_q.we, 1'b1, b_wr_ok);
        rd_a   = port_op(legal, vld_a_q, in_a_q.we, 1'b0, a_rd_ok);
        rd_b   = port_op(legal, vld_b_q, in_b_q.we, 1'b0, b_rd_ok);
    end

    // No reset here: contents are undefined until written; B wins a same-lane collision
    always_ff @(posedge mclk) begin
        for (int j = 0; j < ldpr_pkg::NUM_LANES; j++) begin
            if (wr_a && en_a[j]) begin
                if (cfg.byte8_a) begin
                    mem[widx_a][j*ldpr_pkg::LANE_BITS +: ldpr_pkg::BYTE_BITS] <=
                        pd_a[j*ldpr_pkg::LANE_BITS +: ldpr_pkg::BYTE_BITS];
                end else begin
                    mem[widx_a][j*ldpr_pkg::LANE_BITS +: ldpr_pkg::LANE_BITS] <=
                        pd_a[j*ldpr_pkg::LANE_BITS +: ldpr_pkg::LANE_BITS];
                end
            end
            if (wr_b && en_b[j]) begin
                if (cfg.byte8_b) begin
                    mem[widx_b][j*ldpr_pkg::LANE_BITS +: ldpr_pkg::BYTE_BITS] <=
                        pd_b[j*ldpr_pkg::LANE_BITS +: ldpr_pkg::BYTE_BITS];
                end else begin
                    mem[widx_b][j*ldpr_pkg::LANE_BITS +: ldpr_pkg::LANE_BITS] <=
                        pd_b[j*ldpr_pkg::LANE_BITS +: ldpr_pkg::LANE_BITS];
                end
            end
        end
    end

    // Raw register holds the read word; output register follows on the port enable
    always_ff @(posedge mclk) begin
        if (!rst_n || clr_a) begin
            raw_a_q <= '0;
            out_a_q <= '0;
        end else begin
            if (rd_a) begin
                raw_a_q <= gather(mem[widx_a], lg_a, slot_a, cfg.byte8_a);
            end
            if (ce_a) begin
                out_a_q <= raw_a_q;
            end
        end
    end

    // Port B read path, same shape as port A
    always_ff @(posedge mclk) begin
        if (!rst_n || clr_b) begin
            raw_b_q <= '0;
            out_b_q <= '0;
        end else begin
            if (rd_b) begin
                raw_b_q <= gather(mem[widx_b], lg_b, slot_b, cfg.byte8_b);
            end
            if (ce_b) begin
                out_b_q <= raw_b_q;
            end
        end
    end

    // A 144-bit read on port B uses both ports' read drivers: low half on A, high on B
    always_comb begin
        sel_a = cfg.outreg_a ? out_a_q : raw_a_q;
        sel_b = cfg.outreg_b ? out_b_q : raw_b_q;
        if (wide && cfg.mode != ldpr_pkg::MODE_TRUE_DUAL) begin
            dout_a = sel_b[ldpr_pkg::PORT_DATA-1:0];
            dout_b = sel_b[ldpr_pkg::WORD_BITS-1:ldpr_pkg::PORT_DATA];
        end else begin
            dout_a = sel_a[ldpr_pkg::PORT_DATA-1:0];
            dout_b = sel_b[ldpr_pkg::PORT_DATA-1:0];
        end
    end

endmodule : ldpr_core

// ==== ldpr_pkg.sv ====
// Shared constants, enumerations and carrier structs for the large dual-port RAM block
package ldpr_pkg;

    localparam int TOTAL_BITS = 589824;
    localparam int NUM_WORDS  = 4096;
    localparam int WORD_BITS  = 144;
    localparam int NUM_LANES  = 16;
    localparam int LANE_BITS  = 9;
    localparam int BYTE_BITS  = 8;
    localparam int PORT_DATA  = 72;
    localparam int ADDR_W     = 16;
    localparam int MASK_W     = 8;
    localparam int WIDX_W     = 12;
    localparam int SLOT_W     = 4;
    localparam int LG_MAX     = 4;
    localparam int LG_W       = 3;

    typedef enum logic [1:0] {
        MODE_TRUE_DUAL,
        MODE_SIMPLE_DUAL,
        MODE_SINGLE,
        MODE_FIFO
    } ldpr_mode_e;

    // Port shape: 64K x 9, 32K x 18, 16K x 36, 8K x 72, 4K x 144
    typedef enum logic [2:0] {
        WIDTH_9,
        WIDTH_18,
        WIDTH_36,
        WIDTH_72,
        WIDTH_144
    } ldpr_width_e;

    typedef struct packed {
        ldpr_mode_e  mode;
        ldpr_width_e width_a;
        ldpr_width_e width_b;
        logic        byte8_a;
        logic        byte8_b;
        logic        outreg_a;
        logic        outreg_b;
    } ldpr_cfg_s;

    typedef struct packed {
        logic                 we;
        logic [ADDR_W-1:0]    addr;
        logic [MASK_W-1:0]    mask;
        logic [PORT_DATA-1:0] wdata;
    } ldpr_port_s;

endpackage : ldpr_pkg

// ==== ldpr_chk_assertions.sv ====
// Port checker for the large dual-port RAM block
`timescale 1ns/1ps
module ldpr_chk (
    input wire logic                           mclk,
    input wire logic                           rst_n,
    input wire ldpr_pkg::ldpr_cfg_s            cfg,
    input wire logic                           ce_a,
    input wire logic                           clr_a,
    input wire ldpr_pkg::ldpr_port_s           port_a,
    input wire logic                           ce_b,
    input wire logic                           clr_b,
    input wire ldpr_pkg::ldpr_port_s           port_b,
    input wire logic [ldpr_pkg::PORT_DATA-1:0] dout_a,
    input wire logic [ldpr_pkg::PORT_DATA-1:0] dout_b,
    input wire logic                           cfg_error
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    a_clear_a_zero: assert property (clr_a |=> dout_a == '0)
        else $error("dout_a not cleared");
    a_clear_b_zero: assert property (clr_b |=> dout_b == '0)
        else $error("dout_b not cleared");
    a_true_no_wide: assert property (cfg.mode == ldpr_pkg::MODE_TRUE_DUAL
        && (cfg.width_a == ldpr_pkg::WIDTH_144 || cfg.width_b == ldpr_pkg::WIDTH_144)
        |-> cfg_error)
        else $error("wide shape accepted in true dual mode");
    a_wide_pairs_self: assert property ((cfg.width_a == ldpr_pkg::WIDTH_144)
        != (cfg.width_b == ldpr_pkg::WIDTH_144) |-> cfg_error)
        else $error("wide shape paired with narrow one");
    a_legal_true_dual: assert property (cfg.mode == ldpr_pkg::MODE_TRUE_DUAL
        && cfg.width_a < ldpr_pkg::WIDTH_144 && cfg.width_b < ldpr_pkg::WIDTH_144 |-> !cfg_error)
        else $error("legal true dual shape refused");
    a_wide_sdp_ok: assert property (cfg.mode == ldpr_pkg::MODE_SIMPLE_DUAL
        && cfg.width_a == ldpr_pkg::WIDTH_144 && cfg.width_b == ldpr_pkg::WIDTH_144 |-> !cfg_error)
        else $error("wide simple dual shape refused");
    a_dout_a_cause: assert property ($changed(dout_a) && $stable(cfg)
        && cfg.width_a != ldpr_pkg::WIDTH_144
        |-> $past(ce_a) || $past(ce_a, 2) || $past(clr_a) || !$past(rst_n))
        else $error("dout_a moved without a port A request");
    a_dout_b_cause: assert property ($changed(dout_b) && $stable(cfg)
        |-> $past(ce_b) || $past(ce_b, 2) || $past(clr_b) || !$past(rst_n))
        else $error("dout_b moved without a port B request");
    a_error_freezes: assert property (($stable(cfg) && cfg_error && !clr_a && !clr_b)[*4]
        |-> $stable(dout_a) && $stable(dout_b))
        else $error("read data moved under an illegal shape");
    a_single_b_idle: assert property (($stable(cfg) && !clr_b
        && cfg.mode == ldpr_pkg::MODE_SINGLE)[*4] |-> $stable(dout_b))
        else $error("port B active in single port mode");
endmodule : ldpr_chk

bind ldpr_core ldpr_chk u_chk (.mclk(mclk), .rst_n(rst_n), .cfg(cfg), .ce_a(ce_a),
    .clr_a(clr_a), .port_a(port_a), .ce_b(ce_b), .clr_b(clr_b), .port_b(port_b),
    .dout_a(dout_a), .dout_b(dout_b), .cfg_error(cfg_error));

// ==== ldpr_user.sv ====
// User logic model that drives ports A and B
`timescale 1ns/1ps
module ldpr_user (
    input  wire logic            mclk,
    output logic                 ce_a,
    output logic                 clr_a,
    output ldpr_pkg::ldpr_port_s port_a,
    output logic                 ce_b,
    output logic                 clr_b,
    output ldpr_pkg::ldpr_port_s port_b
);
    // Idle ports scramble their lines so stale values are never trusted
    task automatic idle;
        ce_a = 1'b0;
        ce_b = 1'b0;
        clr_a = 1'b0;
        clr_b = 1'b0;
        port_a = ~port_a;
        port_b = ~port_b;
    endtask : idle
    // Request held for n edges; the select alone picks read or write
    task automatic put(input logic ea, input ldpr_pkg::ldpr_port_s pa,
                       input logic eb, input ldpr_pkg::ldpr_port_s pb, input int n);
        @(posedge mclk);
        #1;
        ce_a = ea;
        port_a = pa;
        ce_b = eb;
        port_b = pb;
        repeat (n) @(posedge mclk);
        #1;
        idle();
    endtask : put
    task automatic clr(input logic ca, input logic cb);
        @(posedge mclk);
        #1;
        clr_a = ca;
        clr_b = cb;
        @(posedge mclk);
        #1;
        idle();
    endtask : clr
    initial begin
        ce_a = 1'b0;
        ce_b = 1'b0;
        clr_a = 1'b0;
        clr_b = 1'b0;
        port_a = '0;
        port_b = '0;
    end
endmodule : ldpr_user

// ==== tb.sv ====
// Self-checking bench for the large dual-port RAM block
`timescale 1ns/1ps
module tb;
    logic                           mclk;
    logic                           rst_n;
    ldpr_pkg::ldpr_cfg_s            cfg;
    logic                           ce_a;
    logic                           clr_a;
    ldpr_pkg::ldpr_port_s           port_a;
    logic                           ce_b;
    logic                           clr_b;
    ldpr_pkg::ldpr_port_s           port_b;
    logic [ldpr_pkg::PORT_DATA-1:0] dout_a;
    logic [ldpr_pkg::PORT_DATA-1:0] dout_b;
    logic                           cfg_error;
    int                             n_fail;
    int                             n_tests;
    logic [143:0]                   e9;
    ldpr_pkg::ldpr_port_s           pa;
    ldpr_pkg::ldpr_port_s           pb;

    ldpr_core u_dut (.mclk(mclk), .rst_n(rst_n), .cfg(cfg), .ce_a(ce_a), .clr_a(clr_a),
        .port_a(port_a), .ce_b(ce_b), .clr_b(clr_b), .port_b(port_b), .dout_a(dout_a),
        .dout_b(dout_b), .cfg_error(cfg_error));
    ldpr_user u_usr (.mclk(mclk), .ce_a(ce_a), .clr_a(clr_a), .port_a(port_a), .ce_b(ce_b),
        .clr_b(clr_b), .port_b(port_b));

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input string nm, input logic [143:0] seen, input logic [143:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    function automatic logic [143:0] mrg(input logic [143:0] old, input logic [143:0] nw,
                                         input logic [15:0] m, input int lb);
        mrg = old;
        for (int i = 0; i < 16 * lb; i++) begin
            if (m[i / lb]) mrg[i] = nw[i];
        end
    endfunction : mrg
    // Byte view of 9-bit lanes, parity bits dropped
    function automatic logic [143:0] pk(input logic [143:0] w);
        pk = '0;
        for (int i = 0; i < 64; i++) begin
            pk[i] = w[(i / 8) * 9 + i % 8];
        end
    endfunction : pk
    task automatic wr(input logic [15:0] ad, input logic [7:0] m, input logic [71:0] d);
        pa = '{1'b1, ad, m, d};
        u_usr.put(1'b1, pa, 1'b0, pa, 1);
    endtask : wr
    // Request held 2 edges for bypass, 3 for the output register
    task automatic rd(input logic b, input logic [15:0] ad, input int n);
        pa = '{1'b0, ad, 8'hFF, 72'h0};
        u_usr.put(!b, pa, b, pa, n);
    endtask : rd

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        print_verdict();
    end
    initial begin
        n_fail = 0;
        n_tests = 0;
        rst_n = 1'b0;
        cfg = '{ldpr_pkg::MODE_TRUE_DUAL, ldpr_pkg::WIDTH_72, ldpr_pkg::WIDTH_72,
                1'b0, 1'b0, 1'b0, 1'b1};
        repeat (2) @(posedge mclk);
        #1 rst_n = 1'b1;
        check("dout_a reset", dout_a, '0);
        wr(16'h0005, 8'hFF, 72'h123456789ABCDEF012);
        wr(16'h0005, 8'hA5, 72'hFFFFFFFFFFFFFFFFFF);
        e9 = mrg(144'h123456789ABCDEF012, {72'h0, 72'hFFFFFFFFFFFFFFFFFF}, 16'h00A5, 9);
        rd(1'b0, 16'h0005, 2);
        check("a masked read", dout_a, e9);
        rd(1'b1, 16'h0005, 3);
        check("b registered read", dout_b, e9);
        u_usr.clr(1'b1, 1'b0);
        check("a cleared", dout_a, '0);
        check("b kept", dout_b, e9);
        {cfg.byte8_a, cfg.byte8_b} = 2'b11;
        wr(16'h0005, 8'h0F, 72'h0);
        rd(1'b1, 16'h0005, 3);
        check("b byte lanes", dout_b, mrg(pk(e9), 144'h0, 16'h000F, 8));
        {cfg.byte8_a, cfg.byte8_b} = 2'b00;
        for (int i = 0; i < 36; i++) begin
            if (i % 9 != 8) e9[i] = 1'b0;
        end
        rd(1'b0, 16'h0005, 2);
        check("parity kept", dout_a, e9);
        cfg.width_a = ldpr_pkg::WIDTH_18;
        e9 = '0;
        for (int i = 0; i < 4; i++) begin
            e9[18 * i +: 18] = 18'h2A5A5 ^ 18'(i * 7);
            wr(16'(i), 8'h03, {~54'h0, e9[18 * i +: 18]});
        end
        rd(1'b1, 16'h0000, 3);
        check("mixed width word", dout_b, e9);
        rd(1'b0, 16'h0002, 2);
        check("x18 read", dout_a, e9[53:36]);
        cfg.width_a = ldpr_pkg::WIDTH_9;
        rd(1'b0, 16'h0005, 2);
        check("x9 read", dout_a, e9[53:45]);
        cfg = '{ldpr_pkg::MODE_TRUE_DUAL, ldpr_pkg::WIDTH_36, ldpr_pkg::WIDTH_72,
                1'b0, 1'b0, 1'b1, 1'b1};
        rd(1'b0, 16'h0001, 3);
        check("x36 registered read", dout_a, e9[71:36]);
        cfg = '{ldpr_pkg::MODE_SINGLE, ldpr_pkg::WIDTH_72, ldpr_pkg::WIDTH_72,
                1'b0, 1'b0, 1'b0, 1'b0};
        rd(1'b1, 16'h0001, 3);
        check("single b ignored", dout_b, e9);
        rd(1'b0, 16'h0000, 2);
        check("single a read", dout_a, e9[71:0]);
        u_usr.clr(1'b0, 1'b1);
        check("b cleared", dout_b, '0);
        for (int m = 1; m < 4; m += 2) begin
            cfg = '{ldpr_pkg::ldpr_mode_e'(m), ldpr_pkg::WIDTH_144, ldpr_pkg::WIDTH_144,
                    1'b0, 1'b0, 1'b0, 1'b1};
            #1 check("wide legal", cfg_error, 1'b0);
            pa = '{1'b1, 16'h0002, 8'hFF, 72'hAAAAAAAAAAAAAAAAAA};
            pb = '{1'b1, 16'h0002, 8'hFF, 72'h555555555555555555};
            u_usr.put(1'b1, pa, 1'b1, pb, 1);
            pa = '{1'b1, 16'h0002, 8'h81, 72'h0};
            pb = '{1'b1, 16'h0002, 8'h18, 72'h0};
            u_usr.put(1'b1, pa, 1'b1, pb, 1);
            e9 = mrg({72'h555555555555555555, 72'hAAAAAAAAAAAAAAAAAA}, '0, 16'h1881, 9);
            pb = '{1'b0, 16'h0002, 8'hFF, 72'h0};
            u_usr.put(1'b0, pa, 1'b1, pb, 3);
            check("wide joined mask", {dout_b, dout_a}, e9);
        end
        cfg.mode = ldpr_pkg::MODE_TRUE_DUAL;
        #1 check("true dual wide", cfg_error, 1'b1);
        pa = '{1'b1, 16'h0002, 8'hFF, 72'h0};
        u_usr.put(1'b1, pa, 1'b0, pb, 1);
        repeat (4) @(posedge mclk);
        #1 cfg = '{ldpr_pkg::MODE_SIMPLE_DUAL, ldpr_pkg::WIDTH_144, ldpr_pkg::WIDTH_72,
                   1'b0, 1'b0, 1'b0, 1'b1};
        #1 check("wide with narrow", cfg_error, 1'b1);
        cfg.width_b = ldpr_pkg::WIDTH_144;
        u_usr.put(1'b0, pa, 1'b1, pb, 3);
        check("refused write", {dout_b, dout_a}, e9);
        print_verdict();
    end
endmodule : tb
